// ---- logic/fbwag_cfg.svh ----
`ifndef FBWAG_CFG_SVH
`define FBWAG_CFG_SVH
// register byte offsets on the apb window
`define FBWAG_OFS_MODE      12'h000
`define FBWAG_OFS_STATUS    12'h004
`define FBWAG_OFS_OPERATE   12'h008
// mode register fields (16-bit, key in upper byte)
`define FBWAG_BIT_ERASE     1
`define FBWAG_BIT_BANKERASE 2
`define FBWAG_BIT_PROGRAM   6
`define FBWAG_BIT_BLOCK     7
// status register fields
`define FBWAG_BIT_BUSY      0
`define FBWAG_BIT_KEY_VIOLATION_FLAG      1
`define FBWAG_BIT_ACCV      2
`define FBWAG_BIT_WAIT      3
`define FBWAG_BIT_LOCK      4
`define FBWAG_BIT_IRQMASK   5
// key values
`define FBWAG_KEY_WRITE     8'hA5
`define FBWAG_KEY_READ      8'h96
// jump-to-self opcode returned while busy
`define FBWAG_JMP_SELF      16'h3FFF
// block geometry: 32 long-words of 4 bytes
`define FBWAG_BLOCK_WORDS   32
// program times in ns, printed values unknown: plain defaults
`define FBWAG_T_FIRST_NS    2000
`define FBWAG_T_MID_NS      1000
`define FBWAG_T_LAST_NS     1500
`define FBWAG_T_ERASE_NS    8000
`define FBWAG_CLK_NS        4
`define FBWAG_CYC(t)        (((t) + `FBWAG_CLK_NS - 1) / `FBWAG_CLK_NS)
`endif

// ---- logic/fbwag_pkg.sv ----
package fbwag_pkg;
  // apb request bundle
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } fbwag_apb_req_s;
  // cpu flash access bundle
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        fetch;
    logic        in_bank;
    logic [15:0] addr;
    logic [15:0] wdata;
  } fbwag_acc_s;
  // controller operation states
  typedef enum logic [4:0] {
    FBWAG_IDLE  = 5'b00001,
    FBWAG_WAITW = 5'b00010,
    FBWAG_PROG  = 5'b00100,
    FBWAG_ERASE = 5'b01000,
    FBWAG_DONE  = 5'b10000
  } fbwag_state_e;
  // kind of timed pulse requested from the timer
  typedef logic [1:0] fbwag_pulse_t;
endpackage

// ---- logic/fbwag_timer.sv ----
`timescale 1ns/10ps
`include "fbwag_cfg.svh"
// counts one programming or erase pulse of a chosen length
module fbwag_timer #(
  parameter int unsigned FIRST_CYC = `FBWAG_CYC(`FBWAG_T_FIRST_NS),
  parameter int unsigned MID_CYC   = `FBWAG_CYC(`FBWAG_T_MID_NS),
  parameter int unsigned LAST_CYC  = `FBWAG_CYC(`FBWAG_T_LAST_NS),
  parameter int unsigned ERASE_CYC = `FBWAG_CYC(`FBWAG_T_ERASE_NS)
) (
  input  wire logic                  i_clk,
  input  wire logic                  i_reset_n,
  input  wire logic                  i_ce,
  input  wire logic                  i_start,
  input  wire fbwag_pkg::fbwag_pulse_t i_kind,
  input  wire logic                  i_abort,
  output logic                       o_done
);
  import fbwag_pkg::*;
  logic [15:0] count;       // cycles left in the pulse
  logic [15:0] next_count;
  logic        next_done;

  // load on start, count down, pulse done at the last cycle
  always_comb begin
    next_count = count;
    next_done  = 1'b0;
    if (i_abort) begin
      next_count = 16'h0000;
    end else if (i_start) begin
      case (i_kind)
        2'd0:    next_count = 16'(FIRST_CYC);
        2'd1:    next_count = 16'(MID_CYC);
        2'd2:    next_count = 16'(LAST_CYC);
        default: next_count = 16'(ERASE_CYC);
      endcase
    end else if (count != 16'h0000) begin
      next_count = count - 16'h0001;
      next_done  = (count == 16'h0001);
    end
  end

  // registers only
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      count  <= 16'h0000;
      o_done <= 1'b0;
    end else if (i_ce) begin
      count  <= next_count;
      o_done <= next_done;
    end
  end
endmodule

// ---- logic/fbwag_top.sv ----
// Our own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`include "fbwag_cfg.svh"
module fbwag_top #(
  parameter int unsigned BLOCK_WORDS = `FBWAG_BLOCK_WORDS
) (
  input  wire logic                    i_clk,
  input  wire logic                    i_reset_n,
  input  wire logic                    i_ce,
  input  wire fbwag_pkg::fbwag_apb_req_s i_apb,
  input  wire fbwag_pkg::fbwag_acc_s   i_acc,
  output logic [31:0]                  o_prdata,
  output logic                         o_pready,
  output logic                         o_pslverr,
  output logic [15:0]                  o_acc_rdata,
  output logic                         o_acc_subst,
  output logic                         o_hv_on,
  output logic                         o_prog_strobe,
  output logic [31:0]                  o_prog_data,
  output logic [15:0]                  o_prog_addr,
  output logic                         o_irq_mask,
  output logic                         o_sys_reset_req
);
  import fbwag_pkg::*;

  fbwag_state_e state;           // operation sequencer
  fbwag_state_e next_state;
  logic [7:0]   mode;            // mode register low byte
  logic [7:0]   next_mode;
  logic         accv;            // sticky access violation
  logic         next_accv;
  logic         key_violation_flag;            // sticky key violation
  logic         next_key_violation_flag;
  logic         lock;            // write-protect bit
  logic         next_lock;
  logic         wait_ok;         // long-word accept flag
  logic         next_wait_ok;
  logic [5:0]   lw_count;        // long-words programmed in block
  logic [5:0]   next_lw_count;
  logic [31:0]  lw_data;         // long-word assembly
  logic [31:0]  next_lw_data;
  logic [1:0]   half_seen;       // which halves are written
  logic [1:0]   next_half_seen;
  logic [15:0]  lw_addr;         // aligned address of the long-word
  logic [15:0]  next_lw_addr;
  logic         bank_op;         // current erase is bank erase
  logic         next_bank_op;
  logic         t_start;         // timer start request
  fbwag_pulse_t t_kind;          // timer pulse kind
  logic         t_done;          // timer finished
  logic         t_abort;         // timer abort
  logic [31:0]  next_prdata;
  logic         next_pready;
  logic         next_pslverr;
  logic [15:0]  next_acc_rdata;
  logic         next_acc_subst;
  logic         next_prog_strobe;
  logic         next_sysrst;
  logic         busy;            // any operation running
  logic         blk;             // block write mode

  // true on the access edge of an apb transfer
  function automatic logic apb_hit(input fbwag_apb_req_s r);
    return r.psel && r.penable;
  endfunction

  // long-word alignment of a byte address
  function automatic logic [15:0] lw_align(input logic [15:0] a);
    return {a[15:2], 2'b00};
  endfunction

  fbwag_timer u_timer (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_ce      (i_ce),
    .i_start   (t_start),
    .i_kind    (t_kind),
    .i_abort   (t_abort),
    .o_done    (t_done)
  );

  assign busy = (state != FBWAG_IDLE);
  assign blk  = mode[`FBWAG_BIT_BLOCK] && mode[`FBWAG_BIT_PROGRAM];

  // sequencer, register file and access arbitration in one next-state block
  always_comb begin
    logic        set_accv;
    logic        exit_blk;
    logic        apb_w;
    logic        keyok;
    logic [11:0] a;
    set_accv         = 1'b0;
    exit_blk         = 1'b0;
    apb_w            = apb_hit(i_apb) && i_apb.pwrite;
    keyok            = (i_apb.pwdata[15:8] == `FBWAG_KEY_WRITE);
    a                = i_apb.paddr;
    next_state       = state;
    next_mode        = mode;
    next_accv        = accv;
    next_key_violation_flag        = key_violation_flag;
    next_lock        = lock;
    next_wait_ok     = wait_ok;
    next_lw_count    = lw_count;
    next_lw_data     = lw_data;
    next_half_seen   = half_seen;
    next_lw_addr     = lw_addr;
    next_bank_op     = bank_op;
    next_prdata      = 32'h0000_0000;
    next_pready      = apb_hit(i_apb) && !o_pready;
    next_pslverr     = 1'b0;
    next_acc_rdata   = 16'h0000;
    next_acc_subst   = 1'b0;
    next_prog_strobe = 1'b0;
    next_sysrst      = 1'b0;
    t_start          = 1'b0;
    t_kind           = 2'd1;
    t_abort          = 1'b0;

    // cpu flash accesses, arbitrated by the current operation
    if (i_acc.valid) begin
      if (!busy) begin
        if (i_acc.write) begin
          if (lock || mode[`FBWAG_BIT_PROGRAM:`FBWAG_BIT_PROGRAM] == 1'b0 && !mode[`FBWAG_BIT_BLOCK]
              && !mode[`FBWAG_BIT_ERASE]) begin
            set_accv = 1'b1;
          end else if (mode[`FBWAG_BIT_ERASE]) begin
            next_state   = FBWAG_ERASE;
            next_bank_op = mode[`FBWAG_BIT_BANKERASE];
            t_start      = 1'b1;
            t_kind       = 2'd3;
          end else if (mode[`FBWAG_BIT_BLOCK]) begin
            // long-word gathering: a write outside the current long-word restarts it
            next_half_seen = (lw_align(i_acc.addr) == lw_addr) ? half_seen : 2'b00;
            next_lw_addr   = lw_align(i_acc.addr);
            next_half_seen[i_acc.addr[1]] = 1'b1;
            if (i_acc.addr[1]) next_lw_data[31:16] = i_acc.wdata;
            else               next_lw_data[15:0]  = i_acc.wdata;
            if (next_half_seen == 2'b11) begin
              next_state     = FBWAG_PROG;
              next_half_seen = 2'b00;
              next_lw_count  = 6'd0;
              t_start        = 1'b1;
              t_kind         = blk ? 2'd0 : 2'd1;
            end
          end else begin
            next_state    = FBWAG_PROG;
            next_lw_addr  = i_acc.addr;
            next_lw_data  = {16'h0000, i_acc.wdata};
            t_start       = 1'b1;
          end
        end else begin
          next_acc_rdata = i_acc.wdata;
        end
      end else if (state == FBWAG_ERASE && bank_op) begin
        if (i_acc.write) begin
          set_accv = 1'b1;
        end else if (i_acc.in_bank) begin
          next_acc_subst = 1'b1;
          next_acc_rdata = `FBWAG_JMP_SELF;
        end else begin
          next_acc_rdata = i_acc.wdata;
        end
      end else if (blk && state != FBWAG_ERASE) begin
        if (!wait_ok || i_acc.fetch) begin
          set_accv  = 1'b1;
          exit_blk  = 1'b1;
        end else if (i_acc.write) begin
          next_half_seen = half_seen;
          next_half_seen[i_acc.addr[1]] = 1'b1;
          if (i_acc.addr[1]) next_lw_data[31:16] = i_acc.wdata;
          else               next_lw_data[15:0]  = i_acc.wdata;
          if (next_half_seen == 2'b11) begin
            next_wait_ok   = 1'b0;
            next_half_seen = 2'b00;
            next_lw_addr   = lw_addr + 16'h0004;
            next_state     = FBWAG_PROG;
            t_start        = 1'b1;
            t_kind         = (lw_count == 6'(BLOCK_WORDS - 1)) ? 2'd2 : 2'd1;
          end
        end else begin
          next_acc_subst = 1'b1;
          next_acc_rdata = `FBWAG_JMP_SELF;
        end
      end else begin
        if (i_acc.write) begin
          set_accv = 1'b1;
        end else begin
          next_acc_subst = 1'b1;
          next_acc_rdata = `FBWAG_JMP_SELF;
        end
      end
    end

    // sequencer progress on pulse completion
    if (t_done) begin
      case (state)
        FBWAG_PROG: begin
          next_prog_strobe = 1'b1;
          if (blk) begin
            next_lw_count = lw_count + 6'd1;
            if (lw_count == 6'(BLOCK_WORDS - 1)) begin
              next_state   = FBWAG_DONE;
              next_wait_ok = 1'b1; // wait stays up so the closing mode write is legal
            end else begin
              next_state   = FBWAG_WAITW;
              next_wait_ok = 1'b1;
            end
          end else begin
            next_state = FBWAG_IDLE;
          end
        end
        FBWAG_ERASE: next_state = FBWAG_IDLE;
        default:     next_state = next_state;
      endcase
    end
    // block completes; busy drops when software clears block mode or an illegal access exits the block
    if (state == FBWAG_DONE && !mode[`FBWAG_BIT_BLOCK]) begin
      next_state   = FBWAG_IDLE;
      next_wait_ok = 1'b0;
    end

    // apb register access
    if (apb_w && !o_pready) begin
      // only mapped registers check the key; anything else is refused with an error
      if (!keyok && a <= `FBWAG_OFS_OPERATE && a[1:0] == 2'b00) begin
        next_key_violation_flag   = 1'b1;
        next_sysrst = 1'b1;
      end else if (a == `FBWAG_OFS_MODE) begin
        if (busy && !(blk && wait_ok)) begin
          set_accv = 1'b1;
        end else begin
          next_mode = i_apb.pwdata[7:0];
        end
      end else if (a == `FBWAG_OFS_STATUS) begin
        next_lock = i_apb.pwdata[`FBWAG_BIT_LOCK];
        if (!i_apb.pwdata[`FBWAG_BIT_ACCV]) next_accv = 1'b0;
        if (!i_apb.pwdata[`FBWAG_BIT_KEY_VIOLATION_FLAG]) next_key_violation_flag = 1'b0;
      end else begin
        next_pslverr = 1'b1;
      end
    end else if (apb_hit(i_apb) && !o_pready) begin
      case (a)
        `FBWAG_OFS_MODE:    next_prdata = {16'h0000, `FBWAG_KEY_READ, mode};
        `FBWAG_OFS_STATUS:  next_prdata = {16'h0000, `FBWAG_KEY_READ, 2'b00, busy, lock, wait_ok, accv, key_violation_flag, busy};
        `FBWAG_OFS_OPERATE: next_prdata = {26'h000_0000, lw_count};
        default:            next_pslverr = 1'b1;
      endcase
    end

    // block exit on illegal access sets lock and ends the operation
    if (exit_blk) begin
      next_lock      = 1'b1;
      next_mode      = 8'h00;
      next_wait_ok   = 1'b0;
      next_half_seen = 2'b00;
      next_state     = FBWAG_IDLE;
      t_abort        = 1'b1;
    end
    // set wins over a software clear in the same cycle
    if (set_accv) next_accv = 1'b1;
  end

  // state registers; reset also aborts any erase
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state     <= FBWAG_IDLE;
      mode      <= 8'h00;
      accv      <= 1'b0;
      key_violation_flag      <= 1'b0;
      lock      <= 1'b1;
      wait_ok   <= 1'b0;
      lw_count  <= 6'd0;
      lw_data   <= 32'h0000_0000;
      half_seen <= 2'b00;
      lw_addr   <= 16'h0000;
      bank_op   <= 1'b0;
    end else if (i_ce) begin
      state     <= next_state;
      mode      <= next_mode;
      accv      <= next_accv;
      key_violation_flag      <= next_key_violation_flag;
      lock      <= next_lock;
      wait_ok   <= next_wait_ok;
      lw_count  <= next_lw_count;
      lw_data   <= next_lw_data;
      half_seen <= next_half_seen;
      lw_addr   <= next_lw_addr;
      bank_op   <= next_bank_op;
    end
  end

  // output registers; hv stays on across the whole block
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_prdata        <= 32'h0000_0000;
      o_pready        <= 1'b0;
      o_pslverr       <= 1'b0;
      o_acc_rdata     <= 16'h0000;
      o_acc_subst     <= 1'b0;
      o_hv_on         <= 1'b0;
      o_prog_strobe   <= 1'b0;
      o_prog_data     <= 32'h0000_0000;
      o_prog_addr     <= 16'h0000;
      o_irq_mask      <= 1'b0;
      o_sys_reset_req <= 1'b0;
    end else if (i_ce) begin
      o_prdata        <= next_prdata;
      o_pready        <= next_pready;
      o_pslverr       <= next_pslverr;
      o_acc_rdata     <= next_acc_rdata;
      o_acc_subst     <= next_acc_subst;
      o_hv_on         <= (next_state != FBWAG_IDLE);
      o_prog_strobe   <= next_prog_strobe;
      o_prog_data     <= lw_data;
      o_prog_addr     <= lw_addr;
      o_irq_mask      <= (next_state != FBWAG_IDLE);
      o_sys_reset_req <= next_sysrst;
    end
  end
endmodule

// ---- verif/fbwag_cpu_model.sv ----
`timescale 1ns/10ps
// cpu running the programming software from ram: one flash access per call
module fbwag_cpu_model (
  input  wire logic             i_clk,
  input  wire logic [15:0]      i_acc_rdata,
  input  wire logic             i_acc_subst,
  output fbwag_pkg::fbwag_acc_s o_acc
);
  import fbwag_pkg::*;
  logic [15:0] seen_rdata; // answer of the last access
  logic        seen_subst; // its substitution marker
  initial begin
    o_acc = '0;
  end
  // valid for one cycle only; afterwards the lines show an inverted pattern,
  // so a design that samples late cannot see the old value by luck
  task automatic access(input logic wr, input logic fe, input logic bk, input logic [15:0] ad,
                        input logic [15:0] wd);
    @(posedge i_clk);
    o_acc <= '{1'b1, wr, fe, bk, ad, wd};
    @(posedge i_clk);
    o_acc <= '{1'b0, 1'b0, 1'b0, 1'b0, ~ad, ~wd};
    @(posedge i_clk);
    seen_rdata = i_acc_rdata;
    seen_subst = i_acc_subst;
  endtask
endmodule

// ---- verif/fbwag_properties.sv ----
`timescale 1ns/10ps
`include "fbwag_cfg.svh"
// port-level timing of the register answer and of busy-time read substitution
module fbwag_checker #(
  parameter int unsigned BLOCK_WORDS = 32
) (
  input wire logic                      i_clk,
  input wire logic                      i_reset_n,
  input wire logic                      i_ce,
  input wire fbwag_pkg::fbwag_apb_req_s i_apb,
  input wire fbwag_pkg::fbwag_acc_s     i_acc,
  input wire logic                      o_pready,
  input wire logic                      o_pslverr,
  input wire logic [15:0]               o_acc_rdata,
  input wire logic                      o_acc_subst,
  input wire logic                      o_hv_on,
  input wire logic                      o_irq_mask,
  input wire logic                      o_sys_reset_req
);
  import fbwag_pkg::*;
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);
  // access phase of a register request that has no answer yet
  sequence s_apb_req;
    i_apb.psel && i_apb.penable && !o_pready && i_ce;
  endsequence
  // a register write whose upper byte is not the key
  sequence s_bad_key;
    s_apb_req ##0 (i_apb.pwrite && i_apb.paddr <= `FBWAG_OFS_OPERATE && i_apb.pwdata[15:8] != `FBWAG_KEY_WRITE);
  endsequence
  property p_pready_answer;
    s_apb_req |=> o_pready;
  endproperty
  property p_pready_pulse;
    o_pready |=> !o_pready;
  endproperty
  property p_pready_cause;
    o_pready |-> $past(i_apb.psel && i_apb.penable);
  endproperty
  property p_unmapped;
    s_apb_req ##0 (i_apb.paddr > `FBWAG_OFS_OPERATE) |=> o_pready && o_pslverr;
  endproperty
  property p_key_reset;
    s_bad_key |-> ##[1:2] o_sys_reset_req;
  endproperty
  property p_irq_mask;
    o_hv_on |-> o_irq_mask;
  endproperty
  property p_subst_value;
    o_acc_subst |-> o_acc_rdata == `FBWAG_JMP_SELF;
  endproperty
  property p_subst_cause;
    o_acc_subst |-> $past(o_hv_on && i_acc.valid && !i_acc.write);
  endproperty
  property p_idle_pass;
    i_acc.valid && !i_acc.write && !o_hv_on |=> !o_acc_subst && o_acc_rdata == $past(i_acc.wdata);
  endproperty
  a_pready_answer: assert property (p_pready_answer) else $error("register answer late");
  a_pready_pulse: assert property (p_pready_pulse) else $error("register answer too long");
  a_pready_cause: assert property (p_pready_cause) else $error("answer without request");
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  a_key_reset: assert property (p_key_reset) else $error("bad key gave no reset request");
  a_irq_mask: assert property (p_irq_mask) else $error("interrupts open while busy");
  a_subst_value: assert property (p_subst_value) else $error("substituted word wrong");
  a_subst_cause: assert property (p_subst_cause) else $error("substitution while idle");
  a_idle_pass: assert property (p_idle_pass) else $error("idle read not passed through");
endmodule

bind fbwag_top fbwag_checker #(.BLOCK_WORDS(BLOCK_WORDS)) chk_u (.i_clk(i_clk), .i_reset_n(i_reset_n),
  .i_ce(i_ce), .i_apb(i_apb), .i_acc(i_acc), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .o_acc_rdata(o_acc_rdata), .o_acc_subst(o_acc_subst), .o_hv_on(o_hv_on), .o_irq_mask(o_irq_mask),
  .o_sys_reset_req(o_sys_reset_req));

// ---- verif/fbwag_top_test.sv ----
`timescale 1ns/10ps
`include "fbwag_cfg.svh"
module fbwag_top_test;
  import fbwag_pkg::*;
  localparam int unsigned NWORDS = 4; // short block keeps the run brief
  logic           clk, reset_n, ce, pready, pslverr, subst, hv_on, strobe, irq_mask, sys_rst, rst_seen;
  fbwag_apb_req_s apb;
  fbwag_acc_s     acc;
  logic [31:0]    prdata, prog_data, rd, lw;
  logic [15:0]    acc_rdata, prog_addr;
  int             err_total, check_count, seed, k, v, n;
  fbwag_top #(.BLOCK_WORDS(NWORDS)) dut_u (.i_clk(clk), .i_reset_n(reset_n), .i_ce(ce), .i_apb(apb),
    .i_acc(acc), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .o_acc_rdata(acc_rdata),
    .o_acc_subst(subst), .o_hv_on(hv_on), .o_prog_strobe(strobe), .o_prog_data(prog_data),
    .o_prog_addr(prog_addr), .o_irq_mask(irq_mask), .o_sys_reset_req(sys_rst));
  fbwag_cpu_model cpu_u (.i_clk(clk), .i_acc_rdata(acc_rdata), .i_acc_subst(subst), .o_acc(acc));
  always #2 clk = ~clk;
  // the key-fault request lasts one cycle; latch it as it rises so the check after the transfer sees it
  always @(posedge sys_rst) begin
    rst_seen = 1'b1;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_rng(input string what, input int lo, input int hi, input int got);
    check_count++;
    if (got < lo || got > hi) begin
      err_total++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask
  // one apb transfer; request held until pready is seen at an edge
  task automatic apb_xfer(input logic wr, input logic [11:0] ad, input logic [31:0] wd);
    n = 0;
    @(posedge clk);
    apb <= '{1'b1, 1'b0, wr, ad, wd};
    @(posedge clk);
    apb.penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    chk("pready", 1'b1, pready);
    apb <= '{1'b0, 1'b0, 1'b0, ~ad, ~wd};
  endtask
  task automatic reg_wr(input logic [11:0] ad, input logic [7:0] val);
    apb_xfer(1'b1, ad, {16'h0000, `FBWAG_KEY_WRITE, val});
  endtask
  task automatic reg_rd(input logic [11:0] ad);
    apb_xfer(1'b0, ad, 32'h0000_0000);
  endtask
  // software waits on a status bit, bounded
  task automatic poll(input int b, input logic val);
    for (int i = 0; i < 3000; i++) begin
      reg_rd(`FBWAG_OFS_STATUS);
      if (rd[b] === val) break;
    end
    chk("status poll", val, rd[b]);
  endtask
  task automatic send_lw(input logic [15:0] ad, input logic [31:0] w);
    cpu_u.access(1'b1, 1'b0, 1'b0, ad, w[15:0]);
    cpu_u.access(1'b1, 1'b0, 1'b0, ad + 16'h0002, w[31:16]);
  endtask
  function automatic int exp_cyc(input int i);
    if (i == 0) return `FBWAG_CYC(`FBWAG_T_FIRST_NS);
    if (i == NWORDS - 1) return `FBWAG_CYC(`FBWAG_T_LAST_NS);
    return `FBWAG_CYC(`FBWAG_T_MID_NS);
  endfunction
  task automatic idle_op;
    reg_wr(`FBWAG_OFS_MODE, 8'h00);
    reg_wr(`FBWAG_OFS_STATUS, 8'h00);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // hang guard sized well above the expected run
  initial begin
    #200000;
    err_total++;
    end_of_test();
  end
  initial begin
    clk = 1'b0;
    seed = 90631;
    err_total = 0;
    check_count = 0;
    ce = 1'b1;
    reset_n = 1'b0;
    rst_seen = 1'b0;
    apb = '0;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    reg_rd(`FBWAG_OFS_MODE);
    chk("mode reset", 32'h0000_9600, rd);
    reg_rd(`FBWAG_OFS_STATUS);
    chk("status reset", 32'h0000_9610, rd);
    for (k = 0; k < 4; k++) begin
      apb_xfer(k[0], {10'($unsigned($random(seed)) % 1021 + 3), 2'b00}, $random(seed));
      chk("slverr", 1'b1, pslverr);
    end
    // flash write with no mode selected
    reg_wr(`FBWAG_OFS_STATUS, 8'h00);
    cpu_u.access(1'b1, 1'b0, 1'b0, 16'hF000, 16'h1234);
    reg_rd(`FBWAG_OFS_STATUS);
    chk("accv no mode", 1'b1, rd[`FBWAG_BIT_ACCV]);
    idle_op();
    $display("test registers done");
    // full block, long-words with random data
    reg_wr(`FBWAG_OFS_MODE, 8'hC0);
    for (k = 0; k < NWORDS; k++) begin
      lw = $random(seed);
      send_lw(16'hF000 + 16'(4 * k), lw);
      n = 0;
      while (strobe !== 1'b1 && n < 2000) begin
        @(posedge clk);
        n++;
      end
      chk_rng("pulse length", exp_cyc(k) - 4, exp_cyc(k) + 4, n);
      chk("program data", lw, prog_data);
      chk("program addr", 16'hF000 + 16'(4 * k), prog_addr);
      chk("hv held", 1'b1, hv_on);
      chk("irq masked", 1'b1, irq_mask);
      poll(`FBWAG_BIT_WAIT, 1'b1);
      chk("busy held", 1'b1, rd[`FBWAG_BIT_BUSY]);
      cpu_u.access(1'b0, 1'b0, 1'b0, 16'hF000, 16'h5A5A);
      chk("read with wait", 1'b1, cpu_u.seen_subst);
    end
    reg_wr(`FBWAG_OFS_MODE, 8'h00);
    poll(`FBWAG_BIT_BUSY, 1'b0);
    chk("accv clean", 1'b0, rd[`FBWAG_BIT_ACCV]);
    reg_wr(`FBWAG_OFS_STATUS, 8'h00);
    lw = $random(seed);
    cpu_u.access(1'b0, 1'b1, 1'b0, 16'hF000, lw[15:0]);
    chk("fetch after busy", {1'b0, lw[15:0]}, {cpu_u.seen_subst, cpu_u.seen_rdata});
    $display("test block done");
    // block abort: read while programming, then fetch while waiting
    for (v = 0; v < 2; v++) begin
      reg_wr(`FBWAG_OFS_MODE, 8'hC0);
      send_lw(16'hF100, $random(seed));
      if (v == 1) begin
        poll(`FBWAG_BIT_WAIT, 1'b1);
      end else begin
        reg_wr(`FBWAG_OFS_MODE, 8'hC0);
        reg_rd(`FBWAG_OFS_STATUS);
        chk("mode write no wait", 1'b1, rd[`FBWAG_BIT_ACCV]);
      end
      cpu_u.access(1'b0, v[0], 1'b0, 16'hF100, 16'h0F0F);
      poll(`FBWAG_BIT_BUSY, 1'b0);
      chk("abort flags", 2'b11, {rd[`FBWAG_BIT_LOCK], rd[`FBWAG_BIT_ACCV]});
      idle_op();
    end
    $display("test abort done");
    // long-word, segment erase, bank erase: what the cpu sees while busy
    for (v = 0; v < 3; v++) begin
      reg_wr(`FBWAG_OFS_MODE, v == 0 ? 8'h80 : (v == 1 ? 8'h02 : 8'h06));
      send_lw(16'hF200, $random(seed));
      lw = $random(seed);
      cpu_u.access(1'b0, 1'b0, 1'b0, 16'hF300, lw[15:0]);
      chk("read other", v == 2 ? {1'b0, lw[15:0]} : 17'h1_3FFF, {cpu_u.seen_subst, cpu_u.seen_rdata});
      cpu_u.access(1'b0, 1'b1, 1'b1, 16'hF200, lw[31:16]);
      chk("fetch busy", 17'h1_3FFF, {cpu_u.seen_subst, cpu_u.seen_rdata});
      cpu_u.access(1'b1, 1'b0, 1'b1, 16'hF204, lw[15:0]);
      poll(`FBWAG_BIT_BUSY, 1'b0);
      chk("write busy accv", 1'b1, rd[`FBWAG_BIT_ACCV]);
      idle_op();
    end
    $display("test busy access done");
    // key fault, then a reset in the middle of an erase
    apb_xfer(1'b1, `FBWAG_OFS_MODE, 32'h0000_5A00);
    chk("reset request", 1'b1, rst_seen);
    reg_rd(`FBWAG_OFS_STATUS);
    chk("key flag", 1'b1, rd[`FBWAG_BIT_KEY_VIOLATION_FLAG]);
    idle_op();
    reg_wr(`FBWAG_OFS_MODE, 8'h02);
    cpu_u.access(1'b1, 1'b0, 1'b0, 16'hF000, 16'h0000);
    poll(`FBWAG_BIT_BUSY, 1'b1);
    reset_n <= 1'b0;
    @(posedge clk);
    @(posedge clk);
    chk("hv after reset", 1'b0, hv_on);
    reset_n <= 1'b1;
    reg_rd(`FBWAG_OFS_STATUS);
    chk("busy after reset", 1'b0, rd[`FBWAG_BIT_BUSY]);
    $display("test key and reset done");
    end_of_test();
  end
endmodule
